//--- src/osc_consts.svh
/*
 * Constants of the oscillator select and status block: register offsets,
 * unlock keys, field positions, reset values and multiplier factors.
 * Assumes it is included by bare name; the include guard makes a repeat inclusion per compile unit harmless.
 */
`ifndef OSC_CONSTS_SVH
`define OSC_CONSTS_SVH

// ==========================================================================
// register map (byte addresses)
`define OSC_ADDR_W 8
`define OSC_OFF_CTRL 8'h00
`define OSC_OFF_UNLOCK 8'h04

// ==========================================================================
// unlock keys, written in this order to the unlock register
`define OSC_KEY_FIRST 32'hAA996655
`define OSC_KEY_SECOND 32'h556699AA
`define OSC_UNLOCK_BIT 0

// ==========================================================================
// control register fields
`define OSC_MULT_HI 18
`define OSC_MULT_LO 16
`define OSC_CUR_HI 14
`define OSC_CUR_LO 12
`define OSC_REQ_HI 10
`define OSC_REQ_LO 8
`define OSC_LOCK_BIT 7
`define OSC_USB_PLL_LOCKED_BIT 6
`define OSC_SYS_PLL_LOCKED_BIT 5
`define OSC_SLEEP_BIT 4
`define OSC_FAIL_BIT 3
`define OSC_SM_DISABLE_BIT 1

// ==========================================================================
// reset values
`define OSC_MULT_RST 3'h0
`define OSC_SRC_RST 3'h0
`define OSC_SM_RST 2'h0
`define OSC_ST_RST 4'h0
`define OSC_WORD_ZERO 32'h00000000

// ==========================================================================
// multiplier factors per select code
`define OSC_FACTOR_0 5'h0F
`define OSC_FACTOR_1 5'h10
`define OSC_FACTOR_2 5'h11
`define OSC_FACTOR_3 5'h12
`define OSC_FACTOR_4 5'h13
`define OSC_FACTOR_5 5'h14
`define OSC_FACTOR_6 5'h15
`define OSC_FACTOR_7 5'h18

`endif

//--- src/osc_pkg.sv
/*
 * Types of the oscillator select and status block.
 * Assumes osc_consts.svh supplies the numeric constants.
 */
package osc_pkg;

    // clock source codes, shared by current and requested fields
    typedef enum logic [2:0] {
        SRC_FAST_RC = 3'h0,
        SRC_FAST_RC_WITH_PLL = 3'h1,
        SRC_PRIMARY = 3'h2,
        SRC_PRIMARY_PLL = 3'h3,
        SRC_SECONDARY = 3'h4,
        SRC_LOW_POWER_RC = 3'h5,
        SRC_FAST_RC_DIV16 = 3'h6,
        SRC_FAST_RC_DIVIDER = 3'h7
    } osc_src_t;

    // sequencer states, gray along init0 -> init1 -> idle -> switch
    typedef enum logic [1:0] {
        ST_INIT0 = 2'h0,
        ST_INIT1 = 2'h1,
        ST_IDLE = 2'h3,
        ST_SWITCH = 2'h2
    } osc_state_t;

endpackage

//--- src/osc_sel_top.sv
/*
 * Oscillator select and status: control register with unlock, PLL
 * multiplier select, clock switch sequencing, lock and fail status.
 * Assumes a clock mux outside that answers o_switch_req with a level
 * i_switch_ack, and PLL, monitor and config inputs from other domains.
 */
// The register addresses and the address-and-strobe port are this design's own decisions.
`timescale 1ns/10ps
`include "osc_consts.svh"

module osc_sel_top (
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic [`OSC_ADDR_W-1:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    input wire logic [2:0] i_default_source_config,
    input wire logic [1:0] i_switch_monitor_config,
    input wire logic i_usb_pll_locked,
    input wire logic i_sys_pll_locked,
    input wire logic i_clock_fail,
    input wire logic i_switch_ack,
    input wire logic i_wait_exec,
    output osc_pkg::osc_src_t o_current_clock_source,
    output osc_pkg::osc_src_t o_target_source,
    output logic o_switch_req,
    output logic [4:0] o_pll_factor,
    output logic o_enter_sleep,
    output logic o_enter_idle
);
    import osc_pkg::*;

    // ======================================================================
    // input synchronisers
    logic [2:0] cfg_src_m_r;
    logic [2:0] cfg_src_r;
    logic [1:0] cfg_sm_m_r;
    logic [1:0] cfg_sm_r;
    logic [3:0] st_m_r;
    logic [3:0] st_r;

    // two stages for every strap and status input
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cfg_src_m_r <= `OSC_SRC_RST;
            cfg_src_r <= `OSC_SRC_RST;
            cfg_sm_m_r <= `OSC_SM_RST;
            cfg_sm_r <= `OSC_SM_RST;
            st_m_r <= `OSC_ST_RST;
            st_r <= `OSC_ST_RST;
        end else begin
            cfg_src_m_r <= i_default_source_config;
            cfg_src_r <= cfg_src_m_r;
            cfg_sm_m_r <= i_switch_monitor_config;
            cfg_sm_r <= cfg_sm_m_r;
            st_m_r <= {i_usb_pll_locked, i_sys_pll_locked, i_clock_fail,
                       i_switch_ack};
            st_r <= st_m_r;
        end
    end

    // st_r order: usb lock, sys lock, clock fail, switch ack
    logic usb_lock_s;
    logic sys_lock_s;
    logic fail_s;
    logic ack_s;
    assign usb_lock_s = st_r[3];
    assign sys_lock_s = st_r[2];
    assign fail_s = st_r[1];
    assign ack_s = st_r[0];

    // ======================================================================
    // bus decode and unlock sequence
    logic wr_ctrl;
    logic wr_unlock;
    logic key1_seen_r;
    logic key1_seen_nxt;
    logic unlocked_r;
    logic unlocked_nxt;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    logic [31:0] ctrl_view;

    assign wr_ctrl = i_wr && (i_addr == `OSC_OFF_CTRL);
    assign wr_unlock = i_wr && (i_addr == `OSC_OFF_UNLOCK);

    always_comb begin
        key1_seen_nxt = key1_seen_r;
        unlocked_nxt = unlocked_r;
        if (wr_unlock) begin
            key1_seen_nxt = (i_wdata == `OSC_KEY_FIRST);
            unlocked_nxt = key1_seen_r && (i_wdata == `OSC_KEY_SECOND);
        end else if (wr_ctrl) begin
            // any control write, taken or not, relocks
            key1_seen_nxt = 1'b0;
            unlocked_nxt = 1'b0;
        end
        // read data stands one cycle after the strobe, else zero
        rdata_nxt = `OSC_WORD_ZERO;
        if (i_rd) begin
            unique case (i_addr)
                `OSC_OFF_CTRL: rdata_nxt = ctrl_view;
                `OSC_OFF_UNLOCK: rdata_nxt[`OSC_UNLOCK_BIT] = unlocked_r;
                default: rdata_nxt = `OSC_WORD_ZERO;
            endcase
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            key1_seen_r <= 1'b0;
            unlocked_r <= 1'b0;
            rdata_r <= `OSC_WORD_ZERO;
        end else begin
            key1_seen_r <= key1_seen_nxt;
            unlocked_r <= unlocked_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign o_rdata = rdata_r;

    // ======================================================================
    // control fields and switch sequencer
    osc_state_t state_r;
    osc_state_t state_nxt;
    logic [2:0] mult_r;
    logic [2:0] mult_nxt;
    osc_src_t cur_r;
    osc_src_t cur_nxt;
    osc_src_t req_r;
    osc_src_t req_nxt;
    osc_src_t tgt_r;
    osc_src_t tgt_nxt;
    logic lock_r;
    logic lock_nxt;
    logic sleep_r;
    logic sleep_nxt;
    logic fail_r;
    logic fail_nxt;
    logic sw_req_r;
    logic sw_req_nxt;
    logic warm_r;
    logic warm_nxt;
    logic [4:0] factor_r;
    logic [4:0] factor_nxt;
    logic ent_sleep_r;
    logic ent_sleep_nxt;
    logic ent_idle_r;
    logic ent_idle_nxt;
    logic frozen;
    logic ctrl_take;

    // frozen only when lock is set and switching/monitoring is disabled
    assign frozen = cfg_sm_r[`OSC_SM_DISABLE_BIT] && lock_r;
    assign ctrl_take = wr_ctrl && unlocked_r;

    // bits 15, 11 and 2:0 stay zero
    always_comb begin
        ctrl_view = `OSC_WORD_ZERO;
        ctrl_view[`OSC_MULT_HI:`OSC_MULT_LO] = mult_r;
        ctrl_view[`OSC_CUR_HI:`OSC_CUR_LO] = cur_r;
        ctrl_view[`OSC_REQ_HI:`OSC_REQ_LO] = req_r;
        ctrl_view[`OSC_LOCK_BIT] = lock_r;
        ctrl_view[`OSC_USB_PLL_LOCKED_BIT] = usb_lock_s;
        ctrl_view[`OSC_SYS_PLL_LOCKED_BIT] = sys_lock_s;
        ctrl_view[`OSC_SLEEP_BIT] = sleep_r;
        ctrl_view[`OSC_FAIL_BIT] = fail_r;
    end

    always_comb begin
        state_nxt = state_r;
        mult_nxt = mult_r;
        cur_nxt = cur_r;
        req_nxt = req_r;
        tgt_nxt = tgt_r;
        lock_nxt = lock_r;
        sleep_nxt = sleep_r;
        fail_nxt = fail_r;
        sw_req_nxt = sw_req_r;
        warm_nxt = 1'b1;
        if (ctrl_take) begin
            // sleep select and fail clear stay writable while frozen
            sleep_nxt = i_wdata[`OSC_SLEEP_BIT];
            if (!i_wdata[`OSC_FAIL_BIT]) begin
                fail_nxt = 1'b0;
            end
            if (!frozen) begin
                mult_nxt = i_wdata[`OSC_MULT_HI:`OSC_MULT_LO];
                req_nxt = osc_src_t'(i_wdata[`OSC_REQ_HI:`OSC_REQ_LO]);
                lock_nxt = i_wdata[`OSC_LOCK_BIT];
            end
        end
        // a failure in the clearing cycle still sets the flag
        if (fail_s) begin
            fail_nxt = 1'b1;
        end
        unique case (state_r)
            ST_INIT0: begin
                // one more edge so the straps cross both stages
                if (warm_r) begin
                    state_nxt = ST_INIT1;
                end
            end
            ST_INIT1: begin
                // synchronised straps are valid here
                req_nxt = osc_src_t'(cfg_src_r);
                cur_nxt = osc_src_t'(cfg_src_r);
                state_nxt = ST_IDLE;
            end
            ST_IDLE: begin
                // a held ack from the last switch must drop first
                if (req_r != cur_r && !ack_s) begin
                    tgt_nxt = req_r;
                    sw_req_nxt = 1'b1;
                    state_nxt = ST_SWITCH;
                end
            end
            ST_SWITCH: begin
                // current source moves only on the synchronised ack
                if (ack_s) begin
                    cur_nxt = tgt_r;
                    sw_req_nxt = 1'b0;
                    state_nxt = ST_IDLE;
                end
            end
        endcase
    end

    // ======================================================================
    // multiplier decode and wait handling
    always_comb begin
        unique case (mult_r)
            3'h0: factor_nxt = `OSC_FACTOR_0;
            3'h1: factor_nxt = `OSC_FACTOR_1;
            3'h2: factor_nxt = `OSC_FACTOR_2;
            3'h3: factor_nxt = `OSC_FACTOR_3;
            3'h4: factor_nxt = `OSC_FACTOR_4;
            3'h5: factor_nxt = `OSC_FACTOR_5;
            3'h6: factor_nxt = `OSC_FACTOR_6;
            3'h7: factor_nxt = `OSC_FACTOR_7;
        endcase
        // one-cycle pulses, a clock after the wait strobe
        ent_sleep_nxt = i_wait_exec && sleep_r;
        ent_idle_nxt = i_wait_exec && !sleep_r;
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_r <= ST_INIT0;
            mult_r <= `OSC_MULT_RST;
            cur_r <= SRC_FAST_RC;
            req_r <= SRC_FAST_RC;
            tgt_r <= SRC_FAST_RC;
            lock_r <= 1'b0;
            sleep_r <= 1'b0;
            fail_r <= 1'b0;
            sw_req_r <= 1'b0;
            warm_r <= 1'b0;
            factor_r <= `OSC_FACTOR_0;
            ent_sleep_r <= 1'b0;
            ent_idle_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            mult_r <= mult_nxt;
            cur_r <= cur_nxt;
            req_r <= req_nxt;
            tgt_r <= tgt_nxt;
            lock_r <= lock_nxt;
            sleep_r <= sleep_nxt;
            fail_r <= fail_nxt;
            sw_req_r <= sw_req_nxt;
            warm_r <= warm_nxt;
            factor_r <= factor_nxt;
            ent_sleep_r <= ent_sleep_nxt;
            ent_idle_r <= ent_idle_nxt;
        end
    end

    // ======================================================================
    // outputs, each straight from a flip-flop
    assign o_current_clock_source = cur_r;
    assign o_target_source = tgt_r;
    assign o_switch_req = sw_req_r;
    assign o_pll_factor = factor_r;
    assign o_enter_sleep = ent_sleep_r;
    assign o_enter_idle = ent_idle_r;

endmodule

//--- verif/osc_sel_assertions.sv
/* checker of the oscillator select block ports.
   assumes osc_sel_top ports, osc_pkg and osc_consts.svh. */
`timescale 1ns/10ps
`include "osc_consts.svh"
module osc_sel_assertions (
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic [`OSC_ADDR_W-1:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [31:0] o_rdata,
    input wire logic [2:0] i_default_source_config,
    input wire logic [1:0] i_switch_monitor_config,
    input wire logic i_usb_pll_locked,
    input wire logic i_sys_pll_locked,
    input wire logic i_clock_fail,
    input wire logic i_switch_ack,
    input wire logic i_wait_exec,
    input wire osc_pkg::osc_src_t o_current_clock_source,
    input wire osc_pkg::osc_src_t o_target_source,
    input wire logic o_switch_req,
    input wire logic [4:0] o_pll_factor,
    input wire logic o_enter_sleep,
    input wire logic o_enter_idle
);
    import osc_pkg::*;
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);
    // =====
    // sequences
    sequence ctrl_rd;
        i_rd && i_addr == `OSC_OFF_CTRL;
    endsequence
    sequence sw_hold;
        o_switch_req && $stable(o_current_clock_source);
    endsequence
    sequence sw_done;
        !o_switch_req && o_current_clock_source == $past(o_target_source);
    endsequence
    // =====
    // properties
    AST_WAIT_MODE: assert property (i_wait_exec |=>
        o_enter_sleep ^ o_enter_idle) else $error("no single wait mode");
    AST_NO_MODE: assert property (!i_wait_exec |=>
        !o_enter_sleep && !o_enter_idle) else $error("mode without wait");
    AST_FACTOR: assert property (
        o_pll_factor inside {[5'h0F:5'h15], 5'h18})
        else $error("illegal pll factor");
    AST_RSVD: assert property (!o_rdata[15] && !o_rdata[11])
        else $error("reserved bit set");
    AST_SWITCH: assert property (o_switch_req |=> sw_hold or sw_done)
        else $error("current source moved mid switch");
    AST_ACK: assert property ($fell(o_switch_req) |->
        $past(i_switch_ack, 2)) else $error("switch ended without ack");
    AST_TARGET: assert property ($rose(o_switch_req) |->
        o_target_source != o_current_clock_source)
        else $error("switch to same source");
    AST_SYS_PLL_LOCKED: assert property ($stable(i_sys_pll_locked)[*3]
        ##0 ctrl_rd |=> o_rdata[`OSC_SYS_PLL_LOCKED_BIT] == $past(i_sys_pll_locked))
        else $error("sys lock bit wrong");
    AST_USB_PLL_LOCKED: assert property ($stable(i_usb_pll_locked)[*3]
        ##0 ctrl_rd |=> o_rdata[`OSC_USB_PLL_LOCKED_BIT] == $past(i_usb_pll_locked))
        else $error("usb lock bit wrong");
    AST_FAIL: assert property (i_clock_fail[*4] ##0 ctrl_rd |=>
        o_rdata[`OSC_FAIL_BIT]) else $error("fail flag not set");
endmodule

bind osc_sel_top osc_sel_assertions chk_u (.i_mclk, .i_rst_n, .i_addr,
    .i_wdata, .i_wr, .i_rd, .o_rdata, .i_default_source_config,
    .i_switch_monitor_config, .i_usb_pll_locked, .i_sys_pll_locked,
    .i_clock_fail, .i_switch_ack, .i_wait_exec, .o_current_clock_source,
    .o_target_source, .o_switch_req, .o_pll_factor, .o_enter_sleep,
    .o_enter_idle);

//--- verif/oscillator_select_status_tb.sv
/* bench of the oscillator select block.
   assumes osc_sel_top, osc_pkg and osc_consts.svh. */
`timescale 1ns/10ps
`include "osc_consts.svh"
module oscillator_select_status_tb;
    import osc_pkg::*;
    logic i_mclk = 0, i_rst_n = 0, i_wr = 0, i_rd = 0, i_wait_exec = 0;
    logic i_usb_pll_locked = 0, i_sys_pll_locked = 0;
    logic i_clock_fail = 0, i_switch_ack = 0;
    logic [`OSC_ADDR_W-1:0] i_addr = 8'h00;
    logic [31:0] i_wdata = 32'h0, o_rdata, rd_q;
    logic [2:0] i_default_source_config = 3'h2;
    logic [1:0] i_switch_monitor_config = 2'h0;
    logic [4:0] o_pll_factor;
    logic o_switch_req, o_enter_sleep, o_enter_idle;
    osc_src_t o_current_clock_source, o_target_source;
    int mismatches = 0, comparisons = 0, cycles = 0;
    logic [4:0] factors [8] = '{5'h0F, 5'h10, 5'h11, 5'h12, 5'h13, 5'h14,
        5'h15, 5'h18};
    osc_sel_top dut_u (.i_mclk, .i_rst_n, .i_addr, .i_wdata, .i_wr, .i_rd,
        .o_rdata, .i_default_source_config, .i_switch_monitor_config,
        .i_usb_pll_locked, .i_sys_pll_locked, .i_clock_fail, .i_switch_ack,
        .i_wait_exec, .o_current_clock_source, .o_target_source,
        .o_switch_req, .o_pll_factor, .o_enter_sleep, .o_enter_idle);
    always #25 i_mclk = ~i_mclk;
    // =====
    // helpers
    task automatic chk(input string nm, input logic [31:0] e,
        input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_mclk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'h1;
        @(posedge i_mclk);
        i_wr <= 1'h0;
    endtask
    task automatic rd_ctrl();
        @(posedge i_mclk);
        i_addr <= `OSC_OFF_CTRL;
        i_rd <= 1'h1;
        @(posedge i_mclk);
        i_rd <= 1'h0;
        #1 rd_q = o_rdata;
    endtask
    task automatic ulw(input logic [31:0] d);
        wr(`OSC_OFF_UNLOCK, `OSC_KEY_FIRST);
        wr(`OSC_OFF_UNLOCK, `OSC_KEY_SECOND);
        wr(`OSC_OFF_CTRL, d);
    endtask
    // fail bit written as 1 so it is never cleared
    function automatic logic [31:0] cw(input logic [2:0] m,
        input logic [2:0] s, input logic lk, input logic slp);
        return {13'h0, m, 5'h0, s, lk, 2'h0, slp, 1'h1, 3'h0};
    endfunction
    // =====
    // scenarios
    task automatic t_reset();
        rd_ctrl();
        chk("cur", 32'h2, rd_q[14:12]);
        chk("req", 32'h2, rd_q[10:8]);
        chk("factor", 32'h0F, o_pll_factor);
    endtask
    task automatic t_nolock();
        wr(`OSC_OFF_CTRL, cw(3'h5, 3'h2, 1'h0, 1'h0));
        rd_ctrl();
        chk("mult", 32'h0, rd_q[18:16]);
        chk("rsvd", 32'h0, {rd_q[15], rd_q[11]});
    endtask
    task automatic t_mult();
        for (int k = 0; k < 8; k++) begin
            ulw(cw(k[2:0], 3'h2, 1'h0, 1'h0));
            repeat (2) @(posedge i_mclk);
            chk("factor", factors[k], o_pll_factor);
        end
    endtask
    task automatic t_wait(input logic slp);
        ulw(cw(3'h0, 3'h2, 1'h0, slp));
        @(posedge i_mclk);
        i_wait_exec <= 1'h1;
        @(posedge i_mclk);
        i_wait_exec <= 1'h0;
        #1;
        chk("sleep", slp, o_enter_sleep);
        chk("idle", !slp, o_enter_idle);
    endtask
    // failure held across the read; the next call drops it
    task automatic t_status(input logic u);
        @(posedge i_mclk);
        i_usb_pll_locked <= u;
        i_sys_pll_locked <= !u;
        i_clock_fail <= u;
        repeat (5) @(posedge i_mclk);
        rd_ctrl();
        chk("usb lock", u, rd_q[6]);
        chk("sys lock", !u, rd_q[5]);
        chk("fail", 32'h1, rd_q[3]);
        if (!u) begin
            ulw(cw(3'h0, 3'h2, 1'h0, 1'h0) & ~32'h00000008);
            rd_ctrl();
            chk("fail clear", 32'h0, rd_q[3]);
        end
    endtask
    task automatic t_switch(input logic [2:0] s);
        int n;
        n = 0;
        ulw(cw(3'h0, s, 1'h0, 1'h0));
        while (o_switch_req !== 1'h1 && n < 20) begin
            @(posedge i_mclk);
            #1;
            n++;
        end
        chk("switch req", 32'h1, o_switch_req);
        repeat (3) @(posedge i_mclk);
        chk("target", s, o_target_source);
        chk("old cur", 3'(s - 3'h1), o_current_clock_source);
        i_switch_ack <= 1'h1;
        while (o_switch_req !== 1'h0 && n < 40) begin
            @(posedge i_mclk);
            #1;
            n++;
        end
        chk("switch end", 32'h0, o_switch_req);
        @(posedge i_mclk);
        i_switch_ack <= 1'h0;
        rd_ctrl();
        chk("cur field", s, rd_q[14:12]);
    endtask
    task automatic t_freeze();
        ulw(cw(3'h1, 3'h2, 1'h1, 1'h0));
        ulw(cw(3'h2, 3'h2, 1'h0, 1'h0));
        repeat (2) @(posedge i_mclk);
        chk("factor", 32'h11, o_pll_factor);
        i_switch_monitor_config <= 2'h2;
        ulw(cw(3'h3, 3'h2, 1'h1, 1'h0));
        ulw(cw(3'h5, 3'h4, 1'h0, 1'h0));
        repeat (4) @(posedge i_mclk);
        chk("factor", 32'h12, o_pll_factor);
        chk("switch", 32'h0, o_switch_req);
    endtask
    // =====
    // run control
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    always @(posedge i_mclk) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            summarize();
        end
    end
    initial begin
        repeat (12) @(posedge i_mclk);
        i_rst_n <= 1'h1;
        repeat (4) @(posedge i_mclk);
        t_reset();
        t_nolock();
        t_mult();
        t_wait(1'h1);
        t_wait(1'h0);
        t_status(1'h1);
        t_status(1'h0);
        for (int k = 0; k < 8; k++) begin
            t_switch(k[2:0] + 3'h3);
        end
        t_freeze();
        summarize();
    end
endmodule
